// ==== common/drd_pkg.sv ====
// Package for the disk read DMA controller: register map, command fields,
// on-disk format counts and state encodings.
// Assumes a single system clock; all users import drd_pkg::*.
package drd_pkg;
   // Register indices on the plain register port
   localparam logic [3:0] REG_CMD_A     = 4'h0;
   localparam logic [3:0] REG_CMD_B     = 4'h1;
   localparam logic [3:0] REG_SECTOR    = 4'h2;
   localparam logic [3:0] REG_WCOUNT    = 4'h3;
   localparam logic [3:0] REG_MEM_ADDR  = 4'h4;
   localparam logic [3:0] REG_STATUS    = 4'h5;
   localparam logic [3:0] REG_SILO      = 4'h6;
   localparam logic [3:0] REG_DRV_SHIFT = 4'h7;
   // Command register B fields
   localparam int CMDB_FUNC_LSB  = 0;
   localparam int CMDB_MAINT_BIT = 3;
   localparam int CMDB_IE_BIT    = 4;
   localparam int CMDB_DRV_LSB   = 5;
   localparam int CMDB_EMA_LSB   = 7;
   localparam int CMDB_MODE8_BIT = 10;
   // Command register A fields
   localparam int CMDA_HEAD_BIT  = 6;
   // Function codes
   localparam logic [2:0] FN_MAINT    = 3'h0;
   localparam logic [2:0] FN_RESET    = 3'h1;
   localparam logic [2:0] FN_STATUS   = 3'h2;
   localparam logic [2:0] FN_SEEK     = 3'h3;
   localparam logic [2:0] FN_RD_HDR   = 3'h4;
   localparam logic [2:0] FN_WRITE    = 3'h5;
   localparam logic [2:0] FN_READ     = 3'h6;
   localparam logic [2:0] FN_READ_NOH = 3'h7;
   // Status register bits
   localparam int ST_DONE = 0;
   localparam int ST_OPI  = 1;
   localparam int ST_HNF  = 2;
   localparam int ST_HEADER_CRC_ERROR = 3;
   localparam int ST_PAYLOAD_CRC_ERROR = 4;
   localparam int ST_DLT  = 5;
   // On-disk format
   localparam int HDR_BITS       = 48;
   localparam int DATA_BYTES     = 256;
   localparam int DATA_BITS      = 2048;
   localparam int CRC_BITS       = 16;
   localparam int WORDS12_SECTOR = 170;
   localparam int SHIFT_BITS     = 16;
   localparam int NUM_DRIVES     = 4;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   // Headers tried before giving up
   localparam int HDR_TRIES_MAX  = 64;
   // Header-less read window, in microseconds and cycles at 10 MHz
   localparam int CLK_MHZ        = 10;
   localparam int NOHDR_WIN_US   = 300;
   localparam int NOHDR_WIN_CYC  = NOHDR_WIN_US * CLK_MHZ;
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_HDR  = 6'b000010,
      S_GAP  = 6'b000100,
      S_DATA = 6'b001000,
      S_CRC  = 6'b010000,
      S_LOOP = 6'b100000
   } drd_state_t;
   typedef struct packed {
      logic       bit_valid;
      logic       bit_val;
      logic       sector_pulse;
   } drd_serial_t;
   typedef struct packed {
      logic       req;
      logic [14:0] addr;
      logic [11:0] data;
   } drd_dma_t;
endpackage

// ==== core/drd_ctrl.sv ====
// Read-side disk controller: register port, header search, CRC checks,
// 8/12-bit packing into a silo, DMA to memory and overlapped seeks.
// Assumes serial read bits arrive async (synchronised here) and memory
// acknowledges DMA requests with dma_ack on the same clock.
`timescale 1ns/1ps
`default_nettype none
module drd_ctrl
   import drd_pkg::*;
#(
   parameter int SILO_DEPTH = 4
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic [3:0]             reg_addr,
   input  wire logic [11:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [11:0]                 reg_rdata,
   input  wire drd_pkg::drd_serial_t   disk_in,
   input  wire logic [NUM_DRIVES-1:0]  seek_done,
   output logic [NUM_DRIVES-1:0]       seeking,
   output logic                        drv_shift_out,
   output logic                        drv_shift_valid,
   output drd_pkg::drd_dma_t           dma,
   input  wire logic                   dma_ack,
   output logic                        irq
);
   import drd_pkg::*;

   logic [11:0] cmd_a, cmd_b, sector, wcount;
   logic [14:0] mem_addr;
   logic        done, operation_incomplete_error, header_not_found_error, header_crc_error, payload_crc_error, transfer_late_error;
   drd_state_t  state;
   drd_serial_t sync1, sync2;
   logic [15:0] crc, hdr_word;
   logic [11:0] bit_cnt;
   logic [6:0]  hdr_tries;
   logic [11:0] acc;
   logic [3:0]  acc_n;
   logic [15:0] dshift;
   logic [4:0]  dshift_n;
   logic [11:0] silo_mem [SILO_DEPTH];
   logic [2:0]  silo_cnt;
   logic [1:0]  wp, rp;
   logic        push;
   logic [11:0] push_data;
   logic [11:0] nohdr_timer;

   wire mode8   = cmd_b[CMDB_MODE8_BIT];
   wire [2:0] func = cmd_b[CMDB_FUNC_LSB +: 3];
   wire cmdb_wr = reg_wr && reg_addr == REG_CMD_B;
   wire bitv    = sync2.bit_valid;
   wire bitd    = sync2.bit_val;
   wire crc_fb  = crc[15] ^ bitd;
   wire [15:0] crc_nx = {crc[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : 16'h0000);
   wire [11:0] acc_nx = {acc[10:0], bitd};
   wire [3:0] acc_full = mode8 ? 4'h8 : 4'hc;
   wire silo_pop = dma_ack && dma.req;
   wire silo_full = silo_cnt == 3'(SILO_DEPTH);
   // Desired address: sector in low bits, head and cylinder from A
   wire [15:0] want_addr = {4'h0, cmd_a} | {10'h000, sector[5:0]};

   // Two-flop synchroniser for the serial read channel
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= disk_in;
         sync2 <= sync1;
      end
   end

   // Register writes; command B starts a command
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cmd_a  <= 12'h000;
         cmd_b  <= 12'h000;
         sector <= 12'h000;
      end else if (reg_wr && state == S_IDLE) begin
         case (reg_addr)
            REG_CMD_A:  cmd_a  <= reg_wdata;
            REG_CMD_B:  cmd_b  <= reg_wdata;
            REG_SECTOR: sector <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Word count and memory address advance on each DMA word
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wcount   <= 12'h000;
         mem_addr <= 15'h0000;
      end else if (reg_wr && state == S_IDLE &&
                   reg_addr == REG_WCOUNT) begin
         wcount <= reg_wdata;
      end else if (reg_wr && state == S_IDLE &&
                   reg_addr == REG_MEM_ADDR) begin
         mem_addr <= {3'h0, reg_wdata};
      end else if (silo_pop) begin
         wcount   <= wcount + 12'h001;
         mem_addr <= mem_addr + 15'h0001;
      end else if (cmdb_wr && state == S_IDLE) begin
         mem_addr[14:12] <= reg_wdata[CMDB_EMA_LSB +: 3];
      end
   end

   // Drive shift register: loaded on each command, sources ORed
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dshift   <= 16'h0000;
         dshift_n <= 5'h00;
      end else if (cmdb_wr && state == S_IDLE) begin
         dshift   <= {4'h0, cmd_a} | {10'h000, sector[5:0]} |
                     {13'h0000, reg_wdata[2:0]};
         dshift_n <= 5'(SHIFT_BITS);
      end else if (dshift_n != 5'h00) begin
         dshift   <= {dshift[14:0], 1'b0};
         dshift_n <= dshift_n - 5'h01;
      end
   end
   assign drv_shift_out   = dshift[15];
   assign drv_shift_valid = dshift_n != 5'h00;

   // Overlapped seeks, one flag per drive
   genvar g;
   generate
      for (g = 0; g < NUM_DRIVES; g++) begin : g_seek
         always_ff @(posedge core_clk) begin
            if (!rst_n)
               seeking[g] <= 1'b0;
            else if (cmdb_wr && state == S_IDLE &&
                     reg_wdata[2:0] == FN_SEEK &&
                     reg_wdata[CMDB_DRV_LSB +: 2] == 2'(g))
               seeking[g] <= 1'b1;
            else if (seek_done[g])
               seeking[g] <= 1'b0;
         end
      end
   endgenerate

   // Header-less read window timer, restarted after each header the sequencer reads in S_HDR
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         nohdr_timer <= 12'h000;
      else if (state == S_HDR && bitv && bit_cnt == 12'(HDR_BITS - 1))
         nohdr_timer <= 12'(NOHDR_WIN_CYC);
      else if (nohdr_timer != 12'h000)
         nohdr_timer <= nohdr_timer - 12'h001;
   end

   // Sequencer: header search, data field, data CRC, loopback
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state     <= S_IDLE;
         done      <= 1'b1;
         {operation_incomplete_error, header_not_found_error, header_crc_error, payload_crc_error, transfer_late_error} <= 5'h00;
         crc       <= CRC_INIT;
         hdr_word  <= 16'h0000;
         bit_cnt   <= 12'h000;
         hdr_tries <= 7'h00;
         acc       <= 12'h000;
         acc_n     <= 4'h0;
         push      <= 1'b0;
         push_data <= 12'h000;
      end else begin
         push <= 1'b0;
         if (silo_full && push)
            transfer_late_error <= 1'b1;
         case (state)
            S_IDLE: if (cmdb_wr) begin
               done <= 1'b0;
               {operation_incomplete_error, header_not_found_error, header_crc_error, payload_crc_error, transfer_late_error} <= 5'h00;
               bit_cnt   <= 12'h000;
               hdr_tries <= 7'h00;
               crc       <= CRC_INIT;
               acc_n     <= 4'h0;
               if (reg_wdata[CMDB_MAINT_BIT])
                  state <= S_LOOP;
               else if (reg_wdata[2:0] == FN_READ)
                  state <= S_HDR;
               else if (reg_wdata[2:0] == FN_READ_NOH)
                  state <= (nohdr_timer != 12'h000) ? S_GAP : S_HDR;
               else
                  done <= 1'b1;
            end
            S_HDR: if (bitv) begin
               crc     <= crc_nx;
               bit_cnt <= bit_cnt + 12'h001;
               if (bit_cnt < 12'd16)
                  hdr_word <= {hdr_word[14:0], bitd};
               if (bit_cnt == 12'(HDR_BITS - 1)) begin
                  bit_cnt <= 12'h000;
                  crc     <= CRC_INIT;
                  if (func == FN_READ_NOH) begin
                     state <= S_DATA;
                  end else if (crc_nx != 16'h0000) begin
                     header_crc_error <= 1'b1;
                     done <= 1'b1;
                     state <= S_IDLE;
                  end else if (hdr_word == want_addr) begin
                     state <= S_DATA;
                  end else if (hdr_tries == 7'(HDR_TRIES_MAX - 1)) begin
                     operation_incomplete_error  <= 1'b1;
                     header_not_found_error  <= 1'b1;
                     done <= 1'b1;
                     state <= S_IDLE;
                  end else begin
                     hdr_tries <= hdr_tries + 7'h01;
                  end
               end
            end
            S_GAP: if (sync2.sector_pulse) begin
               // The next header passes unchecked, then its data field
               bit_cnt <= 12'h000;
               state   <= S_HDR;
            end
            S_DATA: if (bitv) begin
               crc     <= crc_nx;
               bit_cnt <= bit_cnt + 12'h001;
               acc     <= acc_nx;
               acc_n   <= acc_n + 4'h1;
               if (acc_n == acc_full - 4'h1) begin
                  acc_n <= 4'h0;
                  push  <= wcount != 12'h000;
                  push_data <= mode8 ? {4'h0, acc_nx[7:0]}
                                     : acc_nx;
               end
               if (bit_cnt == 12'(DATA_BITS - 1)) begin
                  // 12-bit mode drops the 8 leftover bits
                  acc_n   <= 4'h0;
                  bit_cnt <= 12'h000;
                  state   <= S_CRC;
               end
            end
            S_CRC: if (bitv) begin
               crc     <= crc_nx;
               bit_cnt <= bit_cnt + 12'h001;
               if (bit_cnt == 12'(CRC_BITS - 1)) begin
                  bit_cnt <= 12'h000;
                  crc     <= CRC_INIT;
                  if (crc_nx != 16'h0000) begin
                     payload_crc_error  <= 1'b1;
                     done  <= 1'b1;
                     state <= S_IDLE;
                  end else if (wcount == 12'h000) begin
                     done  <= 1'b1;
                     state <= S_IDLE;
                  end else begin
                     // Next sector; no seek within a transfer
                     state <= S_HDR;
                  end
               end
            end
            S_LOOP: if (drv_shift_valid) begin
               acc   <= {acc[10:0], drv_shift_out};
               acc_n <= acc_n + 4'h1;
               if (acc_n == 4'h7) begin
                  acc_n     <= 4'h0;
                  push      <= 1'b1;
                  push_data <= {4'h0, acc[6:0], drv_shift_out};
               end
            end else begin
               done  <= 1'b1;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
         if (transfer_late_error && state != S_IDLE) begin
            done  <= 1'b1;
            state <= S_IDLE;
         end
      end
   end

   // Silo: words from disk wait here for DMA or a programmed read
   wire silo_rd = reg_rd && reg_addr == REG_SILO && silo_cnt != 3'h0;
   wire pop_any = silo_pop || silo_rd;
   wire do_push = push && !silo_full;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         silo_cnt <= 3'h0;
         wp <= 2'h0;
         rp <= 2'h0;
      end else begin
         if (do_push) begin
            silo_mem[wp] <= push_data;
            wp <= wp + 2'h1;
         end
         if (pop_any)
            rp <= rp + 2'h1;
         silo_cnt <= silo_cnt + (do_push ? 3'h1 : 3'h0)
                              - (pop_any ? 3'h1 : 3'h0);
      end
   end

   // DMA only for data reads; maintenance loopback stays for the program
   always_comb begin
      dma.req  = silo_cnt != 3'h0 && !cmd_b[CMDB_MAINT_BIT] &&
                 (func == FN_READ || func == FN_READ_NOH);
      dma.addr = mem_addr;
      dma.data = silo_mem[rp];
   end

   assign irq = done && cmd_b[CMDB_IE_BIT];

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         reg_rdata <= 12'h000;
      else if (reg_rd) begin
         case (reg_addr)
            REG_CMD_A:    reg_rdata <= cmd_a;
            REG_CMD_B:    reg_rdata <= cmd_b;
            REG_SECTOR:   reg_rdata <= sector;
            REG_WCOUNT:   reg_rdata <= wcount;
            REG_MEM_ADDR: reg_rdata <= mem_addr[11:0];
            REG_STATUS:   reg_rdata <= {6'h00, transfer_late_error, payload_crc_error, header_crc_error, header_not_found_error, operation_incomplete_error,
                                        done};
            REG_SILO:     reg_rdata <= silo_cnt != 3'h0 ? silo_mem[rp]
                                                        : 12'h000;
            default:      reg_rdata <= 12'h000;
         endcase
      end else
         reg_rdata <= 12'h000;
   end

   a_irq_done: assert property (@(posedge core_clk) disable iff (!rst_n)
      irq |-> done)
      else $error("irq without done");
   a_wc_step: assert property (@(posedge core_clk) disable iff (!rst_n)
      silo_pop |=> wcount == $past(wcount) + 12'h001)
      else $error("word count did not step");
   a_start: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cmdb_wr && state == S_IDLE && reg_wdata[2:0] == FN_READ &&
       !reg_wdata[CMDB_MAINT_BIT]) |=> !done && state == S_HDR)
      else $error("read did not start");
   a_byte8: assert property (@(posedge core_clk) disable iff (!rst_n)
      (push && mode8) |-> push_data[11:8] == 4'h0)
      else $error("upper bits not zero");
   a_end: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == S_CRC && bitv && bit_cnt == 12'd15 && wcount == 12'h000
       && !transfer_late_error) |=> done)
      else $error("no end at zero count");
   a_dlt: assert property (@(posedge core_clk) disable iff (!rst_n)
      (push && silo_full) |=> transfer_late_error)
      else $error("late not flagged");
   a_data_after_hdr: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (state == S_DATA && $past(state) == S_HDR) |->
      ($past(hdr_word) == $past(want_addr) || func == FN_READ_NOH))
      else $error("data without matching header");
   a_seek: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cmdb_wr && state == S_IDLE && reg_wdata[2:0] == FN_SEEK &&
       !seek_done[reg_wdata[CMDB_DRV_LSB +: 2]])
      |=> seeking[$past(reg_wdata[CMDB_DRV_LSB +: 2])])
      else $error("seek flag not set");
endmodule // drd_ctrl
`default_nettype wire

// ==== test/drd_ctrl_tb.sv ====
// Bench for drd_ctrl: register traffic, a memory that acks DMA at random
// and the drive model. Assumes the model's one-bit-per-two-clocks stream.
`timescale 1ns/1ps
`default_nettype none
module drd_ctrl_tb;
   import drd_pkg::*;
   logic        core_clk, rst_n, reg_wr, reg_rd, dma_ack, irq, ack_en;
   logic        drv_shift_out, drv_shift_valid, rd_pend;
   logic [3:0]  reg_addr, seek_done, seeking;
   logic [11:0] reg_wdata, reg_rdata, ma;
   logic [15:0] cap;
   logic [7:0]  salt;
   logic [5:0]  sec;
   drd_serial_t disk_in;
   drd_dma_t    dma;
   logic [26:0] exp_dma[$];
   logic [11:0] exp_rd[$];
   int          num_errors = 0;
   int          n_checks = 0;
   int          seed = 32'hc3481031;

   drd_ctrl u_drd_ctrl (.core_clk(core_clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disk_in(disk_in),
      .seek_done(seek_done), .seeking(seeking),
      .drv_shift_out(drv_shift_out), .drv_shift_valid(drv_shift_valid),
      .dma(dma), .dma_ack(dma_ack), .irq(irq));
   drd_disk_model u_drd_disk_model (.core_clk(core_clk), .disk_in(disk_in));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic check(input logic [26:0] seen, input logic [26:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("Checks made %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [11:0] e);
      exp_rd.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   // Sets up a read and notes every DMA word the memory should receive
   task automatic rdcmd(input logic [2:0] fn, input logic m8, input int nw,
                        input int ne);
      logic [11:0] w;
      logic [7:0]  b8;
      int          b;
      ma   = 12'($random(seed)) & 12'h7ff;
      salt = 8'($random(seed));
      sec  = 6'($random(seed)) & 6'h3e;
      wr(REG_MEM_ADDR, ma);
      wr(REG_WCOUNT, 12'(-nw));
      wr(REG_SECTOR, {6'h00, sec});
      wr(REG_CMD_A, 12'h000);
      wr(REG_CMD_B, {1'b0, m8, 7'h52, fn});
      wr(REG_MEM_ADDR, 12'h000);
      check(irq, 1'b0);
      for (int k = 0; k < ne; k++) begin
         for (int j = 0; j < 12; j++) begin
            b = 12 * k + j;
            b8 = salt ^ 8'(b / 8);
            w[11 - j] = b8[7 - b % 8];
         end
         if (m8)
            w = {4'h0, salt ^ 8'(k)};
         exp_dma.push_back({3'h5, ma + 12'(k), w});
      end
   endtask
   task automatic fin(input logic [11:0] st, input string name);
      for (int i = 0; i < 30000 && irq !== 1'b1; i++) @(posedge core_clk);
      check(irq, 1'b1);
      check(27'(exp_dma.size()), 27'h0);
      rd(REG_STATUS, st);
      $display("Test %s finished", name);
   endtask

   // Result watcher: read data the cycle after the strobe, DMA on ack
   always @(posedge core_clk) begin
      rd_pend <= reg_rd;
      dma_ack <= ack_en & 1'($random(seed));
      if (drv_shift_valid === 1'b1)
         cap <= {cap[14:0], drv_shift_out};
      if (rd_pend)
         check(reg_rdata, exp_rd.pop_front());
      if (dma.req === 1'b1 && dma_ack)
         check({dma.addr, dma.data}, exp_dma.pop_front());
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      num_errors++;
      $display("Error at %0t: run did not finish", $time);
      complete_run;
   end

   initial begin
      {rst_n, reg_wr, reg_rd, dma_ack, ack_en, rd_pend} = '0;
      {reg_addr, reg_wdata, seek_done, cap} = '0;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(REG_STATUS, 12'h001);
      rd(4'h9, 12'h000);
      check(irq, 1'b0);
      $display("Test reset finished");
      for (int d = 0; d < NUM_DRIVES; d++)
         wr(REG_CMD_B, 12'(d << CMDB_DRV_LSB) | 12'(FN_SEEK));
      check(seeking, 4'hf);
      seek_done <= 4'hf;
      @(posedge core_clk);
      seek_done <= 4'h0;
      repeat (4) @(posedge core_clk);
      check(seeking, 4'h0);
      $display("Test seeks finished");
      // Loopback only with seek and 8-bit mode, as the host must
      wr(REG_CMD_B, 12'h418 | 12'(FN_SEEK));
      fin(12'h001, "loopback");
      rd(REG_SILO, {4'h0, cap[15:8]});
      rd(REG_SILO, {4'h0, cap[7:0]});
      // Let any header-less window lapse first
      repeat (3100) @(posedge core_clk);
      ack_en <= 1'b1;
      rdcmd(FN_READ_NOH, 1'b1, 4, 4);
      u_drd_disk_model.send_sector(16'(sec ^ 6'h01), 1, 1, salt, 0);
      fin(12'h001, "noheader");
      rdcmd(FN_READ, 1'b1, 4, 4);
      u_drd_disk_model.send_sector(16'(sec ^ 6'h01), 0, 0, salt, 0);
      u_drd_disk_model.send_sector(16'(sec), 0, 1, salt, 0);
      fin(12'h001, "read8");
      rd(REG_WCOUNT, 12'h000);
      rd(REG_MEM_ADDR, ma + 12'd4);
      rdcmd(FN_READ, 1'b0, 3, 3);
      u_drd_disk_model.send_sector(16'(sec), 0, 1, salt, 1);
      fin(12'h011, "read12");
      rdcmd(FN_READ, 1'b1, 4, 0);
      u_drd_disk_model.send_sector(16'(sec), 1, 1, salt, 0);
      fin(12'h009, "badheader");
      rdcmd(FN_READ, 1'b1, 4, 0);
      repeat (64) u_drd_disk_model.send_sector(16'(sec) | 16'h8000, 0, 0,
                                               salt, 0);
      fin(12'h007, "wrongtrack");
      // Header-less read issued inside the window after the last header
      rdcmd(FN_READ_NOH, 1'b1, 4, 4);
      u_drd_disk_model.send_sector(16'h0000, 1, 1, salt, 0);
      fin(12'h001, "window");
      ack_en <= 1'b0;
      rdcmd(FN_READ, 1'b1, 8, 0);
      u_drd_disk_model.send_sector(16'(sec), 0, 1, salt, 0);
      fin(12'h021, "late");
      complete_run;
   end
endmodule // drd_ctrl_tb
`default_nettype wire

// ==== test/drd_disk_model.sv ====
// Drive model: sends one sector slot per call, one bit every two clocks.
// Assumes the bench calls send_sector right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module drd_disk_model
   import drd_pkg::*;
(
   input  wire logic            core_clk,
   output drd_pkg::drd_serial_t disk_in
);
   logic [15:0] crc;
   initial disk_in = '0;
   // Data line flips between bits so a stale level is never a valid bit
   task automatic put_bit(input logic b);
      @(posedge core_clk);
      disk_in.bit_valid <= 1'b1;
      disk_in.bit_val   <= b;
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
      @(posedge core_clk);
      disk_in.bit_valid <= 1'b0;
      disk_in.bit_val   <= ~b;
   endtask
   task automatic put_crc(input logic bad);
      logic [15:0] c;
      c = crc ^ {15'h0000, bad};
      for (int i = 15; i >= 0; i--) put_bit(c[i]);
   endtask
   task automatic send_sector(input logic [15:0] haddr, input logic hbad,
                              input logic dat, input logic [7:0] salt,
                              input logic dbad);
      logic [7:0] byt;
      @(posedge core_clk);
      disk_in.sector_pulse <= 1'b1;
      @(posedge core_clk);
      disk_in.sector_pulse <= 1'b0;
      crc = CRC_INIT;
      for (int i = 15; i >= 0; i--) put_bit(haddr[i]);
      for (int i = 0; i < 16; i++) put_bit(1'b0);
      put_crc(hbad);
      repeat (8) @(posedge core_clk);
      if (dat) begin
         crc = CRC_INIT;
         for (int i = 0; i < DATA_BITS; i++) begin
            byt = salt ^ 8'(i / 8);
            put_bit(byt[7 - i % 8]);
         end
         put_crc(dbad);
      end
      repeat (8) @(posedge core_clk);
   endtask
endmodule // drd_disk_model
`default_nettype wire
